/* core/wcc_pkg.sv */
// Constants, register map and types of the window check and clip unit
package wcc_pkg;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [7:0] REG_CTRL  = 8'h00;
    localparam logic [7:0] REG_WLOW  = 8'h04;
    localparam logic [7:0] REG_WHIGH = 8'h08;
    localparam logic [7:0] REG_DESTINATION_START_ADDRESS = 8'h0C;
    localparam logic [7:0] REG_DEXT  = 8'h10;
    localparam logic [7:0] REG_SADDR = 8'h14;
    localparam logic [7:0] REG_CMD   = 8'h18;
    localparam logic [7:0] REG_STAT  = 8'h1C;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_MODE_MSB = 1;
    localparam int CTRL_VIE_BIT  = 2;
    localparam int CTRL_GIE_BIT  = 3;
    localparam int CMD_OP_LSB    = 0;
    localparam int CMD_OP_MSB    = 1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_V_BIT    = 1;
    localparam int STAT_Z_BIT    = 2;
    localparam int STAT_PEND_BIT = 3;
    localparam int STAT_ABRT_BIT = 4;
    localparam int X_LSB         = 0;
    localparam int X_MSB         = 15;
    localparam int Y_LSB         = 16;
    localparam int Y_MSB         = 31;

    // ************************************************************
    // Values
    // ************************************************************
    localparam logic [31:0]        RST_WORD  = 32'h0000_0000;
    localparam logic [15:0]        COORD_Z   = 16'h0000;
    localparam logic signed [17:0] COORD_ONE = 18'sh00001;

    localparam logic [1:0] MODE_IGNORE = 2'h0;
    localparam logic [1:0] MODE_HIT    = 2'h1;
    localparam logic [1:0] MODE_MISS   = 2'h2;
    localparam logic [1:0] MODE_CLIP   = 2'h3;

    localparam logic [1:0] OP_PIXEL = 2'h0;
    localparam logic [1:0] OP_FILL  = 2'h1;
    localparam logic [1:0] OP_BLT   = 2'h2;
    localparam logic [1:0] OP_CLIP  = 2'h3;

    typedef enum logic [1:0] {ST_IDLE, ST_EVAL, ST_DRAW} wcc_state_t;

endpackage

/* core/wcc_window_check.sv */
// Window check, array preclip and clip operation with APB register access
// Function
// - Mode 0 ignores the window, draws normally, raises no request.
// - Mode 1 pixel: never drawn; request only when pixel is inside.
// - Mode 2 pixel: drawn only inside; request when outside.
// - Mode 3 pixel: drawn only inside; never requests.
// - Pixel overflow: unchanged in mode 0, else set outside, cleared inside.
// - Mode 1 array: nothing drawn; request if any pixel is inside.
// - Mode 1 array hit rewrites start address and extent to the intersection.
// - Mode 1 array: overflow set wholly outside, cleared with request otherwise.
// - Mode 2 array: any pixel outside aborts with request, registers kept.
// - Mode 2 array: wholly inside clears overflow, drawn fully; else sets it.
// - Mode 3 array: only inside pixels drawn, no request, extent unchanged.
// - Mode 3 array: overflow set unless whole array lies inside.
// - Clip mode trims destination first; block transfer source trimmed to match.
// - Array in mode 0 leaves overflow unchanged.
// - Clip operation replaces start address and extent with trimmed values when any part is inside.
// - Clip operation sets zero flag when wholly outside, else clears it.
// - Clip operation sets overflow when any part outside, else clears it.
// - Inside means both coordinates within signed 16-bit inclusive bounds.
// - Start above end on any axis makes the window empty.
// - Violation sets pending; taken only with both enables; always readable.
// - A taken violation aborts the operation, keeping intermediate registers.
`timescale 1ns/100ps

module wcc_window_check #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Pixel write port toward the drawing engine
    output logic                   pix_valid,
    input  wire logic              pix_ready,
    output logic      [15:0]       pix_x,
    output logic      [15:0]       pix_y,
    output logic      [15:0]       pix_src_x,
    output logic      [15:0]       pix_src_y,
    // Status
    output logic                   busy,
    output logic                   win_irq
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        wcc_pkg::wcc_state_t st;
        logic [1:0]          wmode;
        logic [1:0]          mode;
        logic [1:0]          op;
        logic                vie;
        logic                gie;
        logic [31:0]         wlo;
        logic [31:0]         whi;
        logic [31:0]         destination_start_address;
        logic [31:0]         dext;
        logic [31:0]         saddr;
        logic                v;
        logic                z;
        logic                pend;
        logic                abrt;
        logic [15:0]         cx;
        logic [15:0]         cy;
        logic [15:0]         x0;
        logic [15:0]         x1;
        logic [15:0]         y1;
        logic [15:0]         sx;
        logic [15:0]         sy;
        logic [15:0]         sx0;
        logic [31:0]         prdata;
    } wcc_regs_t;

    wcc_regs_t r_q;
    wcc_regs_t r_d;

    logic signed [17:0] wx0, wy0, wx1, wy1;
    logic signed [17:0] ax0, ay0, ax1, ay1;
    logic signed [17:0] ix0, iy0, ix1, iy1;
    logic signed [17:0] iw, ih;
    logic               win_empty, ext_zero, pix_in, any_in, all_in;
    logic               pend_set, taken, go_draw, acc_wr, pend_clr, mapped;
    logic [15:0]        bx0, by0, bx1, by1;
    logic [31:0]        rd;

    function automatic logic signed [17:0] sext(input logic [15:0] v);
        return $signed({{2{v[15]}}, v});
    endfunction

    // ************************************************************
    // Window geometry
    // ************************************************************
    always_comb
    begin
        wx0 = sext(r_q.wlo[wcc_pkg::X_MSB:wcc_pkg::X_LSB]);
        wy0 = sext(r_q.wlo[wcc_pkg::Y_MSB:wcc_pkg::Y_LSB]);
        wx1 = sext(r_q.whi[wcc_pkg::X_MSB:wcc_pkg::X_LSB]);
        wy1 = sext(r_q.whi[wcc_pkg::Y_MSB:wcc_pkg::Y_LSB]);
        ax0 = sext(r_q.destination_start_address[wcc_pkg::X_MSB:wcc_pkg::X_LSB]);
        ay0 = sext(r_q.destination_start_address[wcc_pkg::Y_MSB:wcc_pkg::Y_LSB]);
        ax1 = ax0 + $signed({2'h0, r_q.dext[wcc_pkg::X_MSB:wcc_pkg::X_LSB]}) - wcc_pkg::COORD_ONE;
        ay1 = ay0 + $signed({2'h0, r_q.dext[wcc_pkg::Y_MSB:wcc_pkg::Y_LSB]}) - wcc_pkg::COORD_ONE;
        win_empty = (wx0 > wx1) || (wy0 > wy1);
        ext_zero = (r_q.dext[wcc_pkg::X_MSB:wcc_pkg::X_LSB] == wcc_pkg::COORD_Z)
                 || (r_q.dext[wcc_pkg::Y_MSB:wcc_pkg::Y_LSB] == wcc_pkg::COORD_Z);
        ix0 = (ax0 > wx0) ? ax0 : wx0;
        iy0 = (ay0 > wy0) ? ay0 : wy0;
        ix1 = (ax1 < wx1) ? ax1 : wx1;
        iy1 = (ay1 < wy1) ? ay1 : wy1;
        iw = ix1 - ix0 + wcc_pkg::COORD_ONE;
        ih = iy1 - iy0 + wcc_pkg::COORD_ONE;
        pix_in = !win_empty && (ax0 >= wx0) && (ax0 <= wx1) && (ay0 >= wy0) && (ay0 <= wy1);
        any_in = !win_empty && !ext_zero && (ix0 <= ix1) && (iy0 <= iy1);
        // Zero extent counts as vacuously inside a non-empty window
        all_in = !win_empty && (ext_zero
               || ((ax0 >= wx0) && (ax1 <= wx1) && (ay0 >= wy0) && (ay1 <= wy1)));
    end

    // ************************************************************
    // Register read mux and decode
    // ************************************************************
    always_comb
    begin
        rd = wcc_pkg::RST_WORD;
        mapped = 1'b1;
        case (paddr)
            wcc_pkg::REG_CTRL:
            begin
                rd[wcc_pkg::CTRL_MODE_MSB:wcc_pkg::CTRL_MODE_LSB] = r_q.wmode;
                rd[wcc_pkg::CTRL_VIE_BIT] = r_q.vie;
                rd[wcc_pkg::CTRL_GIE_BIT] = r_q.gie;
            end
            wcc_pkg::REG_WLOW:  rd = r_q.wlo;
            wcc_pkg::REG_WHIGH: rd = r_q.whi;
            wcc_pkg::REG_DESTINATION_START_ADDRESS: rd = r_q.destination_start_address;
            wcc_pkg::REG_DEXT:  rd = r_q.dext;
            wcc_pkg::REG_SADDR: rd = r_q.saddr;
            wcc_pkg::REG_CMD:   rd[wcc_pkg::CMD_OP_MSB:wcc_pkg::CMD_OP_LSB] = r_q.op;
            wcc_pkg::REG_STAT:
            begin
                rd[wcc_pkg::STAT_BUSY_BIT] = (r_q.st != wcc_pkg::ST_IDLE);
                rd[wcc_pkg::STAT_V_BIT]    = r_q.v;
                rd[wcc_pkg::STAT_Z_BIT]    = r_q.z;
                rd[wcc_pkg::STAT_PEND_BIT] = r_q.pend;
                rd[wcc_pkg::STAT_ABRT_BIT] = r_q.abrt;
            end
            default: mapped = 1'b0;
        endcase
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        r_d = r_q;
        pend_set = 1'b0;
        go_draw = 1'b0;
        taken = r_q.vie && r_q.gie;
        acc_wr = psel && penable && pwrite && mapped;
        pend_clr = acc_wr && (paddr == wcc_pkg::REG_STAT) && pwdata[wcc_pkg::STAT_PEND_BIT];
        bx0 = ax0[15:0];
        by0 = ay0[15:0];
        bx1 = ax1[15:0];
        by1 = ay1[15:0];

        // Read data captured in setup so a zero-wait access phase can return it
        if (psel && !penable && !pwrite)
        begin
            r_d.prdata = rd;
        end

        // Geometry writes only while idle; an operation owns them while busy
        if (acc_wr && (r_q.st == wcc_pkg::ST_IDLE))
        begin
            case (paddr)
                wcc_pkg::REG_CTRL:
                begin
                    r_d.wmode = pwdata[wcc_pkg::CTRL_MODE_MSB:wcc_pkg::CTRL_MODE_LSB];
                    r_d.vie   = pwdata[wcc_pkg::CTRL_VIE_BIT];
                    r_d.gie   = pwdata[wcc_pkg::CTRL_GIE_BIT];
                end
                wcc_pkg::REG_WLOW:  r_d.wlo = pwdata;
                wcc_pkg::REG_WHIGH: r_d.whi = pwdata;
                wcc_pkg::REG_DESTINATION_START_ADDRESS: r_d.destination_start_address = pwdata;
                wcc_pkg::REG_DEXT:  r_d.dext = pwdata;
                wcc_pkg::REG_SADDR: r_d.saddr = pwdata;
                wcc_pkg::REG_CMD:
                begin
                    r_d.op = pwdata[wcc_pkg::CMD_OP_MSB:wcc_pkg::CMD_OP_LSB];
                    r_d.mode = r_q.wmode;
                    r_d.abrt = 1'b0;
                    r_d.st = wcc_pkg::ST_EVAL;
                end
                default: ;
            endcase
        end

        unique case (r_q.st)
            wcc_pkg::ST_IDLE: ;
            wcc_pkg::ST_EVAL:
            begin
                r_d.st = wcc_pkg::ST_IDLE;
                unique case (r_q.op)
                    wcc_pkg::OP_PIXEL:
                    begin
                        bx1 = bx0;
                        by1 = by0;
                        if (r_q.mode != wcc_pkg::MODE_IGNORE)
                        begin
                            r_d.v = !pix_in;
                        end
                        unique case (r_q.mode)
                            wcc_pkg::MODE_IGNORE: go_draw = 1'b1;
                            wcc_pkg::MODE_HIT:    pend_set = pix_in;
                            wcc_pkg::MODE_MISS:
                            begin
                                go_draw = pix_in;
                                pend_set = !pix_in;
                            end
                            wcc_pkg::MODE_CLIP:   go_draw = pix_in;
                        endcase
                    end
                    wcc_pkg::OP_CLIP:
                    begin
                        if (any_in)
                        begin
                            r_d.destination_start_address = {iy0[15:0], ix0[15:0]};
                            r_d.dext = {ih[15:0], iw[15:0]};
                        end
                        r_d.z = !any_in;
                        r_d.v = !all_in;
                    end
                    wcc_pkg::OP_FILL, wcc_pkg::OP_BLT:
                    begin
                        unique case (r_q.mode)
                            wcc_pkg::MODE_IGNORE: go_draw = !ext_zero;
                            wcc_pkg::MODE_HIT:
                            begin
                                r_d.v = !any_in;
                                pend_set = any_in;
                                if (any_in)
                                begin
                                    r_d.destination_start_address = {iy0[15:0], ix0[15:0]};
                                    r_d.dext = {ih[15:0], iw[15:0]};
                                end
                            end
                            wcc_pkg::MODE_MISS:
                            begin
                                r_d.v = !all_in;
                                pend_set = !all_in;
                                r_d.abrt = !all_in;
                                go_draw = all_in && !ext_zero;
                            end
                            wcc_pkg::MODE_CLIP:
                            begin
                                r_d.v = !all_in;
                                go_draw = any_in;
                                bx0 = ix0[15:0];
                                by0 = iy0[15:0];
                                bx1 = ix1[15:0];
                                by1 = iy1[15:0];
                            end
                        endcase
                    end
                endcase
                // taken violation ends the operation here
                if (pend_set && taken)
                begin
                    r_d.abrt = 1'b1;
                    go_draw = 1'b0;
                end
                if (go_draw)
                begin
                    r_d.st = wcc_pkg::ST_DRAW;
                    r_d.cx = bx0;
                    r_d.cy = by0;
                    r_d.x0 = bx0;
                    r_d.x1 = bx1;
                    r_d.y1 = by1;
                    // source shifted by the destination trim
                    r_d.sx0 = r_q.saddr[wcc_pkg::X_MSB:wcc_pkg::X_LSB] + (bx0 - ax0[15:0]);
                    r_d.sx = r_q.saddr[wcc_pkg::X_MSB:wcc_pkg::X_LSB] + (bx0 - ax0[15:0]);
                    r_d.sy = r_q.saddr[wcc_pkg::Y_MSB:wcc_pkg::Y_LSB] + (by0 - ay0[15:0]);
                end
            end
            wcc_pkg::ST_DRAW:
            begin
                if (pix_ready)
                begin
                    if (r_q.cx == r_q.x1)
                    begin
                        r_d.cx = r_q.x0;
                        r_d.sx = r_q.sx0;
                        r_d.cy = r_q.cy + 16'h0001;
                        r_d.sy = r_q.sy + 16'h0001;
                        if (r_q.cy == r_q.y1)
                        begin
                            r_d.st = wcc_pkg::ST_IDLE;
                        end
                    end
                    else
                    begin
                        r_d.cx = r_q.cx + 16'h0001;
                        r_d.sx = r_q.sx + 16'h0001;
                    end
                end
            end
        endcase

        r_d.pend = (r_q.pend && !pend_clr) || pend_set;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            r_q <= '0;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign prdata    = r_q.prdata;
    assign pready    = 1'b1;
    assign pslverr   = psel && penable && !mapped;
    assign pix_valid = (r_q.st == wcc_pkg::ST_DRAW);
    assign pix_x     = r_q.cx;
    assign pix_y     = r_q.cy;
    assign pix_src_x = r_q.sx;
    assign pix_src_y = r_q.sy;
    assign busy      = (r_q.st != wcc_pkg::ST_IDLE);
    // Gated request; pending bit keeps the event when gates are closed
    assign win_irq   = r_q.pend && r_q.vie && r_q.gie;

    // ************************************************************
    // Assertions
    // ************************************************************
    AST_MODE0_QUIET: assert property (@(posedge core_clk) disable iff (rst)
        (r_q.st == wcc_pkg::ST_EVAL) && (r_q.mode == wcc_pkg::MODE_IGNORE)
        && (r_q.op != wcc_pkg::OP_CLIP) |-> !pend_set ##1 $stable(r_q.v))
        else $error("mode 0 raised a request or moved overflow");
    AST_HIT_PIXEL: assert property (@(posedge core_clk) disable iff (rst)
        (r_q.st == wcc_pkg::ST_EVAL) && (r_q.op == wcc_pkg::OP_PIXEL)
        && (r_q.mode == wcc_pkg::MODE_HIT) |-> (pend_set == pix_in) ##1 !pix_valid)
        else $error("hit mode pixel drew or misreported");
    AST_MISS_PIXEL: assert property (@(posedge core_clk) disable iff (rst)
        (r_q.st == wcc_pkg::ST_EVAL) && (r_q.op == wcc_pkg::OP_PIXEL)
        && (r_q.mode == wcc_pkg::MODE_MISS) |-> (pend_set == !pix_in))
        else $error("miss mode pixel request wrong");
    AST_CLIP_QUIET: assert property (@(posedge core_clk) disable iff (rst)
        (r_q.st == wcc_pkg::ST_EVAL) && (r_q.mode == wcc_pkg::MODE_CLIP) |-> !pend_set)
        else $error("clip mode requested an interrupt");
    AST_PIXEL_V: assert property (@(posedge core_clk) disable iff (rst)
        (r_q.st == wcc_pkg::ST_EVAL) && (r_q.op == wcc_pkg::OP_PIXEL)
        && (r_q.mode != wcc_pkg::MODE_IGNORE) |=> (r_q.v == !$past(pix_in)))
        else $error("pixel overflow flag wrong");
    AST_HIT_REWRITE: assert property (@(posedge core_clk) disable iff (rst)
        (r_q.st == wcc_pkg::ST_EVAL) && (r_q.op == wcc_pkg::OP_FILL)
        && (r_q.mode == wcc_pkg::MODE_HIT) && any_in
        |=> (r_q.destination_start_address[15:0] == $past(ix0[15:0])) && (r_q.dext[15:0] == $past(iw[15:0])))
        else $error("hit mode intersection not written back");
    AST_HIT_V: assert property (@(posedge core_clk) disable iff (rst)
        (r_q.st == wcc_pkg::ST_EVAL) && (r_q.op != wcc_pkg::OP_PIXEL)
        && (r_q.op != wcc_pkg::OP_CLIP) && (r_q.mode == wcc_pkg::MODE_HIT)
        |=> (r_q.v == !$past(any_in)) && (r_q.pend || !$past(any_in)))
        else $error("hit mode array flag or request wrong");
    AST_MISS_ABORT: assert property (@(posedge core_clk) disable iff (rst)
        (r_q.st == wcc_pkg::ST_EVAL) && (r_q.op == wcc_pkg::OP_BLT)
        && (r_q.mode == wcc_pkg::MODE_MISS) && !all_in
        |=> !busy && $stable(r_q.destination_start_address) && $stable(r_q.dext) && r_q.pend)
        else $error("miss mode array did not abort cleanly");
    AST_CLIP_Z: assert property (@(posedge core_clk) disable iff (rst)
        (r_q.st == wcc_pkg::ST_EVAL) && (r_q.op == wcc_pkg::OP_CLIP)
        |=> (r_q.z == !$past(any_in)))
        else $error("clip operation zero flag wrong");
    AST_CLIP_V: assert property (@(posedge core_clk) disable iff (rst)
        (r_q.st == wcc_pkg::ST_EVAL) && (r_q.op == wcc_pkg::OP_CLIP)
        |=> (r_q.v == !$past(all_in)))
        else $error("clip operation overflow flag wrong");
    AST_MODE_HELD: assert property (@(posedge core_clk) disable iff (rst)
        busy ##1 busy |-> $stable(r_q.mode))
        else $error("window mode changed during an operation");

endmodule

/* dv/testbench.sv */
// Self-checking testbench for the window check and clip unit
`timescale 1ns/100ps

module testbench;
    // ************************************************************
    // Signals
    // ************************************************************
    logic        core_clk  = 1'b0;
    logic        rst       = 1'b1;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic        pix_ready = 1'b0;
    logic [7:0]  paddr     = 8'h00;
    logic [31:0] pwdata    = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, pix_valid, busy, win_irq, err;
    logic [15:0] pix_x, pix_y, pix_src_x, pix_src_y;
    int wx0, wy0, wx1, wy1, dx, dy, w, h, ix0, iy0, iw, ih, ok, any_in, all_in, pin;
    int mode, op, vie, gie, arr, rw, ev, ep, draw, npix, n_mismatch, checks_done, i, k;

    wcc_window_check u_dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_x(pix_x),
        .pix_y(pix_y), .pix_src_x(pix_src_x), .pix_src_y(pix_src_y), .busy(busy),
        .win_irq(win_irq));

    initial forever #10 core_clk = ~core_clk;

    // ************************************************************
    // Report and bus tasks
    // ************************************************************
    task bad(input string m);
        n_mismatch++;
        $display("BAD %0t %s", $time, m);
    endtask

    task chk(input logic [31:0] g, input logic [31:0] e, input string m);
        checks_done++;
        if (g !== e) bad(m);
    endtask

    task end_sim;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        k = 0;
        do begin @(posedge core_clk); k++; end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin bad("bus timeout"); end_sim; end
        rd = prdata; err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    // Stalling engine; clip mode must never offer a pixel outside the window
    always @(posedge core_clk) begin
        pix_ready <= ($urandom % 4) != 0;
        if (pix_valid === 1'b1 && pix_ready === 1'b1) begin
            npix++;
            if (op == 2) chk({16'h0000, pix_src_x - pix_x}, {16'h0000, 16'h0000 - dx[15:0]}, "source x");
            if (op == 2) chk({16'h0000, pix_src_y - pix_y}, {16'h0000, 16'h0000 - dy[15:0]}, "source y");
            if (mode == 3 && !($signed(pix_x) >= wx0 && $signed(pix_x) <= wx1 &&
                $signed(pix_y) >= wy0 && $signed(pix_y) <= wy1)) bad("outside pixel");
        end
    end

    // ************************************************************
    // One operation with its expected outcome
    // ************************************************************
    task run_op;
        apb(1'b1, wcc_pkg::REG_CTRL, {28'h0, gie[0], vie[0], mode[1:0]});
        apb(1'b1, wcc_pkg::REG_WLOW, {wy0[15:0], wx0[15:0]});
        apb(1'b1, wcc_pkg::REG_WHIGH, {wy1[15:0], wx1[15:0]});
        apb(1'b1, wcc_pkg::REG_DEXT - 8'h04, {dy[15:0], dx[15:0]});
        apb(1'b1, wcc_pkg::REG_DEXT, {h[15:0], w[15:0]});
        npix = 0;
        apb(1'b1, wcc_pkg::REG_CMD, {30'h0, op[1:0]});
        k = 0;
        // Busy looked at on the falling edge, once it has settled
        do begin @(negedge core_clk); k++; end while (busy !== 1'b0 && k < 500);
        if (k >= 500) begin bad("busy timeout"); end_sim; end
        ok = wx0 <= wx1 && wy0 <= wy1;
        ix0 = dx > wx0 ? dx : wx0;
        iy0 = dy > wy0 ? dy : wy0;
        iw = ((dx + w - 1 < wx1) ? dx + w - 1 : wx1) - ix0 + 1;
        ih = ((dy + h - 1 < wy1) ? dy + h - 1 : wy1) - iy0 + 1;
        pin = ok && dx >= wx0 && dx <= wx1 && dy >= wy0 && dy <= wy1;
        any_in = ok && w > 0 && h > 0 && iw > 0 && ih > 0;
        all_in = ok && (w == 0 || h == 0 || (ix0 == dx && iy0 == dy && iw == w && ih == h));
        arr = op != 0;
        if (!arr) begin any_in = pin; all_in = pin; end
        ep = 0; draw = 0;
        case (mode)
            0: draw = arr ? w * h : 1;
            1: begin ev = !any_in; ep = any_in; end
            2: begin ev = !all_in; ep = !all_in; draw = all_in ? (arr ? w * h : 1) : 0; end
            default: begin ev = !all_in; draw = arr ? (any_in ? iw * ih : 0) : pin; end
        endcase
        if (op == 3) begin ev = !all_in; ep = 0; draw = 0; end
        rw = any_in && (op == 3 || (mode == 1 && arr));
        chk(npix, draw, "pixel count");
        apb(1'b0, wcc_pkg::REG_STAT, 32'h0);
        chk(rd[1], ev, "overflow flag");
        chk(rd[3], ep, "pending flag");
        chk(win_irq, ep & vie & gie, "interrupt line");
        if (op == 3) chk(rd[2], !any_in, "zero flag");
        apb(1'b0, wcc_pkg::REG_DEXT - 8'h04, 32'h0);
        if (op == 3 || (mode == 1 && arr))
            chk(rd, rw ? {iy0[15:0], ix0[15:0]} : {dy[15:0], dx[15:0]}, "start");
        apb(1'b0, wcc_pkg::REG_DEXT, 32'h0);
        if (!(mode == 2 && arr && op != 3))
            chk(rd, rw ? {ih[15:0], iw[15:0]} : {h[15:0], w[15:0]}, "extent");
        apb(1'b1, wcc_pkg::REG_STAT, 32'h0000_0008);
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        void'($urandom(32'h5aa1));
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        apb(1'b0, wcc_pkg::REG_CTRL, 32'h0);
        chk(rd, wcc_pkg::RST_WORD, "control after reset");
        apb(1'b0, 8'h40, 32'h0);
        chk(err, 1'b1, "unmapped read");
        // First sixteen cover every mode with every operation except mode 0 fill
        for (i = 0; i < 80; i++) begin
            mode = i < 16 ? i % 4 : $urandom % 4;
            op = i < 16 ? i / 4 : $urandom % 4;
            vie = $urandom % 2;
            gie = $urandom % 2;
            wx0 = int'($urandom % 16) - 4;
            wy0 = int'($urandom % 16) - 4;
            wx1 = wx0 + int'($urandom % 12);
            wy1 = wy0 + int'($urandom % 12);
            dx = int'($urandom % 24) - 8;
            dy = int'($urandom % 24) - 8;
            w = $urandom % 8;
            h = $urandom % 8;
            if (i % 5 == 1) wx1 = wx0 - 1;
            if (i % 7 == 2) begin wx0 = dx; wx1 = dx; wy0 = dy; wy1 = dy; end
            if (i % 6 == 3) w = 0;
            // clip operation issued in place of the chosen operation
            if (i % 9 == 4) op = 3;
            run_op;
        end
        end_sim;
    end
endmodule
